// ===== design/dess_top.sv
// Emergency input, torque cutoff status and error history object handling of the drive
`timescale 1ns/1ns
`include "dess_regs.svh"
module dess_top #(
  parameter int RAMP_CYCLES = `DESS_RAMP_CYCLES,
  parameter int HIST_DEPTH  = `DESS_HIST_DEPTH
) (
  input  logic        mclk,
  input  logic        sys_rst,
  input  logic        req_valid,
  input  logic        req_write,
  input  logic [15:0] req_index,
  input  logic [7:0]  req_subindex,
  input  logic [31:0] req_data,
  output logic        rsp_valid,
  output logic [7:0]  rsp_cmd,
  output logic [31:0] rsp_data,
  input  logic        dig_in3,
  input  logic        torque_cutoff_line_a,
  input  logic        torque_cutoff_line_b,
  input  logic        run_req,
  input  logic        standby_req,
  input  logic        disable_req,
  input  logic        dyn_brake_en,
  input  logic        err_valid,
  input  logic [31:0] err_code,
  output logic [15:0] drive_state_word,
  output logic [15:0] drive_ctrl_code,
  output logic        drive_running,
  output logic        ramp_active
);

  dess_pkg::dess_state_t state;
  dess_pkg::dess_state_t next_state;

  logic [2:0]  sync_a;
  logic [2:0]  sync_b;
  logic        in3_level;
  logic        torque_cutoff_input;
  logic        emerg_en;
  logic        emerg_pol;
  logic        emerg;
  logic [31:0] ramp_cnt;
  logic        ramp_done;
  logic        hist_clear;
  logic [7:0]  hist_count;
  logic [31:0] hist_code;
  logic        hist_hit;
  logic [7:0]  next_cmd;
  logic [31:0] next_data;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers reset to idle pin levels (lines powered), so no false cutoff follows reset
  // two-stage capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_a <= `DESS_SYNC_RST;
      sync_b <= `DESS_SYNC_RST;
    end else begin
      sync_a <= {torque_cutoff_line_b, torque_cutoff_line_a, dig_in3};
      sync_b <= sync_a;
    end
  end

  // Lines are powered in normal running; a dead line on either channel means cutoff
  assign in3_level           = sync_b[0];
  assign torque_cutoff_input = !sync_b[1] || !sync_b[2];

  assign emerg = emerg_en && (in3_level ^ emerg_pol);

  ////////////////////////////////////////////////////////////////////////////////
  // Drive state selection; cutoff overrides everything else
  always_comb begin
    next_state = state;
    case (state)
      dess_pkg::DS_DISABLED: begin
        if (standby_req) begin
          next_state = dess_pkg::DS_STANDBY;
        end
      end
      dess_pkg::DS_STANDBY: begin
        if (disable_req) begin
          next_state = dess_pkg::DS_DISABLED;
        end else if (run_req && !emerg) begin
          next_state = dess_pkg::DS_RUN;
        end
      end
      dess_pkg::DS_RUN: begin
        if (emerg) begin
          next_state = dyn_brake_en ? dess_pkg::DS_RAMP : dess_pkg::DS_STANDBY;
        end else if (disable_req) begin
          next_state = dess_pkg::DS_DISABLED;
        end else if (standby_req) begin
          next_state = dess_pkg::DS_STANDBY;
        end
      end
      dess_pkg::DS_RAMP: begin
        if (ramp_done) begin
          next_state = dess_pkg::DS_STANDBY;
        end
      end
      dess_pkg::DS_SAFETY: begin
        // Leaving safety always passes through switch-on-disabled
        if (!torque_cutoff_input) begin
          next_state = dess_pkg::DS_DISABLED;
        end
      end
      default: next_state = dess_pkg::DS_DISABLED;
    endcase
    if (torque_cutoff_input) begin
      next_state = dess_pkg::DS_SAFETY;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= dess_pkg::DS_DISABLED;
    end else begin
      state <= next_state;
    end
  end

  // Deceleration ramp length; counter restarts each time the ramp is entered
  // ramp timing
  always_ff @(posedge mclk) begin
    if (sys_rst || state != dess_pkg::DS_RAMP) begin
      ramp_cnt <= 32'h0;
    end else if (!ramp_done) begin
      ramp_cnt <= ramp_cnt + 32'h1;
    end
  end

  assign ramp_done = ramp_cnt >= 32'(RAMP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Status outputs follow the state being entered, so they match state each cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drive_state_word <= {8'h00, `DESS_SW_DISABLED};
      drive_ctrl_code  <= `DESS_DCS_DISABLED;
      drive_running    <= 1'b0;
      ramp_active      <= 1'b0;
    end else begin
      drive_running    <= next_state == dess_pkg::DS_RUN;
      ramp_active      <= next_state == dess_pkg::DS_RAMP;
      drive_state_word <= 16'h0000;
      drive_state_word[`DESS_SW_EMERG_BIT] <= emerg;
      drive_state_word[`DESS_SW_SAFETY_BIT] <= next_state == dess_pkg::DS_SAFETY;
      case (next_state)
        dess_pkg::DS_DISABLED: begin
          drive_state_word[7:0] <= `DESS_SW_DISABLED;
          drive_ctrl_code       <= `DESS_DCS_DISABLED;
        end
        dess_pkg::DS_RUN: begin
          drive_state_word[7:0] <= `DESS_SW_OP_ENABLED;
          drive_ctrl_code       <= `DESS_DCS_RUN;
        end
        dess_pkg::DS_RAMP: begin
          drive_state_word[7:0] <= `DESS_SW_OP_ENABLED;
          drive_ctrl_code       <= `DESS_DCS_RAMP;
        end
        dess_pkg::DS_SAFETY: begin
          drive_state_word[7:0] <= `DESS_SW_SWITCHED_ON;
          drive_ctrl_code       <= `DESS_DCS_SAFETY;
        end
        default: begin
          drive_state_word[7:0] <= `DESS_SW_SWITCHED_ON;
          drive_ctrl_code       <= `DESS_DCS_STANDBY;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Emergency configuration written by the master; value 1 sets, anything else clears
  // enable store
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      emerg_en  <= `DESS_EMERG_EN_RST;
      emerg_pol <= `DESS_EMERG_POL_RST;
    end else if (req_valid && req_write && req_index == `DESS_OD_EMERG_CFG) begin
      if (req_subindex == `DESS_SUB_EMERG_EN) begin
        emerg_en <= req_data == 32'h1;
      end
      if (req_subindex == `DESS_SUB_EMERG_POL) begin
        emerg_pol <= req_data == 32'h1;
      end
    end
  end

  assign hist_clear = req_valid && req_write && req_index == `DESS_OD_HISTORY
                      && req_subindex == 8'h00 && req_data == 32'h0;

  dess_history #(
    .DEPTH(HIST_DEPTH)
  ) u_history (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .rec_valid(err_valid),
    .rec_code (err_code),
    .clear    (hist_clear),
    .rd_sub   (req_subindex),
    .count    (hist_count),
    .rd_code  (hist_code),
    .rd_hit   (hist_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Object access decode; every request is answered exactly one cycle later
  always_comb begin
    next_cmd  = `DESS_CMD_ABORT;
    next_data = `DESS_AB_NO_OBJ;
    case (req_index)
      `DESS_OD_STATUS: begin
        if (req_write) begin
          next_data = `DESS_AB_READ_ONLY;
        end else if (req_subindex != 8'h00) begin
          next_data = `DESS_AB_NO_SUB;
        end else begin
          next_cmd  = `DESS_CMD_UP16;
          next_data = {16'h0000, drive_state_word};
        end
      end
      `DESS_OD_CTRL_STATE: begin
        if (req_write) begin
          next_data = `DESS_AB_READ_ONLY;
        end else if (req_subindex != 8'h00) begin
          next_data = `DESS_AB_NO_SUB;
        end else begin
          next_cmd  = `DESS_CMD_UP16;
          next_data = {16'h0000, drive_ctrl_code};
        end
      end
      `DESS_OD_SAFETY: begin
        if (req_write) begin
          next_data = `DESS_AB_READ_ONLY;
        end else if (req_subindex != `DESS_SUB_SAFETY) begin
          next_data = `DESS_AB_NO_SUB;
        end else begin
          next_cmd  = `DESS_CMD_UP16;
          next_data = {31'h0, state == dess_pkg::DS_SAFETY};
        end
      end
      `DESS_OD_EMERG_CFG: begin
        if (req_subindex == `DESS_SUB_EMERG_EN || req_subindex == `DESS_SUB_EMERG_POL) begin
          next_cmd  = req_write ? `DESS_CMD_ACK : `DESS_CMD_UP16;
          next_data = req_write ? 32'h0 :
                      {31'h0, req_subindex == `DESS_SUB_EMERG_EN ? emerg_en : emerg_pol};
        end else if (req_subindex == `DESS_SUB_EMERG_ACT) begin
          next_data = `DESS_AB_READ_ONLY;
          if (!req_write) begin
            next_cmd  = `DESS_CMD_UP16;
            next_data = {31'h0, emerg};
          end
        end else begin
          next_data = `DESS_AB_NO_SUB;
        end
      end
      `DESS_OD_HISTORY: begin
        if (req_write) begin
          next_data = req_subindex != 8'h00 ? `DESS_AB_READ_ONLY : `DESS_AB_RANGE;
          if (hist_clear) begin
            next_cmd  = `DESS_CMD_ACK;
            next_data = 32'h0;
          end
        end else if (req_subindex == 8'h00) begin
          next_cmd  = `DESS_CMD_UP8;
          next_data = {24'h0, hist_count};
        end else if (hist_hit) begin
          next_cmd  = `DESS_CMD_UP32;
          next_data = hist_code;
        end else begin
          next_data = `DESS_AB_NO_SUB;
        end
      end
      default: begin
        next_data = `DESS_AB_NO_OBJ;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_cmd   <= 8'h00;
      rsp_data  <= 32'h0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_cmd  <= next_cmd;
        rsp_data <= next_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_emerg_gated : assert property (!emerg_en |=> !drive_state_word[8])
    else $error("emergency bit set while function disabled");

  chk_run_exit : assert property (state == dess_pkg::DS_RUN && emerg && !dyn_brake_en
      && !torque_cutoff_input |=> state == dess_pkg::DS_STANDBY)
    else $error("run not left on emergency input");

  chk_ramp_entry : assert property (state == dess_pkg::DS_RUN && emerg && dyn_brake_en
      && !torque_cutoff_input |=> ramp_active && !drive_running)
    else $error("ramp not started on braked emergency exit");

  chk_run_refused : assert property (emerg |=> !drive_running)
    else $error("run entered with emergency input active");

  chk_bit8_follow : assert property (drive_state_word[8] == $past(emerg))
    else $error("status bit 8 does not follow emergency input");

  chk_standby_word : assert property (state == dess_pkg::DS_RUN && emerg && !dyn_brake_en
      && !torque_cutoff_input |=> drive_state_word[8] && drive_state_word[3:0] == 4'h3)
    else $error("emergency standby pattern wrong");

  chk_cutoff_entry : assert property (torque_cutoff_input |=>
      state == dess_pkg::DS_SAFETY && drive_state_word[14])
    else $error("safety state not entered on cutoff");

  chk_bit14_state : assert property (drive_state_word[14] ==
      (state == dess_pkg::DS_SAFETY))
    else $error("status bit 14 disagrees with state");

  chk_safety_code : assert property (drive_state_word[14] |->
      drive_ctrl_code == `DESS_DCS_SAFETY)
    else $error("control state code not 0x80 in safety");

  chk_empty_abort : assert property (req_valid && !req_write && req_index == `DESS_OD_HISTORY
      && req_subindex != 8'h00 && req_subindex > hist_count
      |=> rsp_valid && rsp_cmd == `DESS_CMD_ABORT)
    else $error("empty history slot not aborted");

  chk_sync_delay : assert property ($rose(dig_in3) ##1 dig_in3 |=> in3_level)
    else $error("input 3 synchroniser latency wrong");

  cov_emerg_exit : cover property (state == dess_pkg::DS_RUN ##1
      state == dess_pkg::DS_STANDBY && drive_state_word[8]);
  cov_safety : cover property (state == dess_pkg::DS_RUN ##1 state == dess_pkg::DS_SAFETY);
  cov_abort : cover property (rsp_valid && rsp_cmd == `DESS_CMD_ABORT);

endmodule // dess_top

// ===== design/dess_regs.svh
// Object dictionary indices, field positions, answer codes and timing for the drive safety block
// What this block does
// - The emergency input does nothing until the master writes 1 to object 0x3008 sub 1.
// - With the emergency function on, an active input 3 drops the drive from run to standby.
// - With the dynamic brake option on, that emergency exit runs a deceleration ramp first.
// - With the emergency function on, no entry into the run state is allowed while input 3 stays at its active level.
// - Status word bit 8 is 1 while the emergency input is active and 0 otherwise.
// - In emergency standby the status word shows the switched-on pattern 0011b with bit 8 set.
// - Object 0x3008 sub 3 reads 1 while the emergency condition is active, else 0.
// - The input is active high; writing 1 to 0x3008 sub 2 makes a low level the active one.
// - An asserted torque cutoff input forces the safety state over every other selection.
// - Status word bit 14 is 1 in the safety state and 0 outside it.
// - Object 0x4000 sub 1 reads 1 in the safety state and 0 otherwise.
// - The drive control state object reads 0x80 in the safety state.
// - Error history sub 0 reads the 8-bit count of recorded emergency entries.
// - Writing 0 to history sub 0 clears all entries and the count, and is acknowledged.
// - History subs 1 to 15 each return one recorded 32-bit emergency code.
// - Reading a history sub with no recorded error is answered by an abort, command 0x80.
`ifndef DESS_REGS_SVH
`define DESS_REGS_SVH

// Object indices
`define DESS_OD_HISTORY      16'h1003
`define DESS_OD_CTRL_STATE   16'h2002
`define DESS_OD_EMERG_CFG    16'h3008
`define DESS_OD_SAFETY       16'h4000
`define DESS_OD_STATUS       16'h6041

// Subindices
`define DESS_SUB_EMERG_EN    8'h01
`define DESS_SUB_EMERG_POL   8'h02
`define DESS_SUB_EMERG_ACT   8'h03
`define DESS_SUB_SAFETY      8'h01

// Answer command bytes
`define DESS_CMD_ACK         8'h60
`define DESS_CMD_UP8         8'h4f
`define DESS_CMD_UP16        8'h4b
`define DESS_CMD_UP32        8'h43
`define DESS_CMD_ABORT       8'h80

// Abort codes
`define DESS_AB_NO_OBJ       32'h0602_0000
`define DESS_AB_READ_ONLY    32'h0601_0002
`define DESS_AB_NO_SUB       32'h0609_0011
`define DESS_AB_RANGE        32'h0609_0030

// Status word fields and state patterns
`define DESS_SW_EMERG_BIT    8
`define DESS_SW_SAFETY_BIT   14
`define DESS_SW_DISABLED     8'h40
`define DESS_SW_SWITCHED_ON  8'h23
`define DESS_SW_OP_ENABLED   8'h27

// Drive control state codes
`define DESS_DCS_DISABLED    16'h0000
`define DESS_DCS_STANDBY     16'h0001
`define DESS_DCS_RUN         16'h0002
`define DESS_DCS_RAMP        16'h0003
`define DESS_DCS_SAFETY      16'h0080

// History depth and reset values
`define DESS_HIST_DEPTH      15
`define DESS_EMERG_EN_RST    1'b0
`define DESS_EMERG_POL_RST   1'b0
`define DESS_SYNC_RST        3'h6

// Deceleration ramp timing
`define DESS_CLK_PERIOD_NS   10
`define DESS_RAMP_TIME_MS    100
`define DESS_RAMP_CYCLES     ((`DESS_RAMP_TIME_MS * 1000000) / `DESS_CLK_PERIOD_NS)

`endif

// ===== design/dess_pkg.sv
// Types shared by the drive safety status block
package dess_pkg;
  typedef enum logic [2:0] {
    DS_DISABLED,
    DS_STANDBY,
    DS_RUN,
    DS_RAMP,
    DS_SAFETY
  } dess_state_t;
endpackage : dess_pkg

// ===== design/dess_history.sv
// Emergency error history store, newest entry at subindex 1
`timescale 1ns/1ns
`include "dess_regs.svh"
module dess_history #(
  parameter int DEPTH = `DESS_HIST_DEPTH
) (
  input  logic        mclk,
  input  logic        sys_rst,
  input  logic        rec_valid,
  input  logic [31:0] rec_code,
  input  logic        clear,
  input  logic [7:0]  rd_sub,
  output logic [7:0]  count,
  output logic [31:0] rd_code,
  output logic        rd_hit
);

  logic [31:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // Entry shift; a record in the clear cycle survives as the only entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    if (g == 0) begin : g_head
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          mem[0] <= 32'h0;
        end else if (rec_valid) begin
          mem[0] <= rec_code;
        end else if (clear) begin
          mem[0] <= 32'h0;
        end
      end
    end else begin : g_tail
      always_ff @(posedge mclk) begin
        if (sys_rst || clear) begin
          mem[g] <= 32'h0;
        end else if (rec_valid) begin
          mem[g] <= mem[g-1];
        end
      end
    end
  end

  // Count saturates at depth; oldest code falls off the end
  // entry count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count <= 8'h00;
    end else if (clear) begin
      count <= {7'h00, rec_valid};
    end else if (rec_valid && count < 8'(DEPTH)) begin
      count <= count + 8'h01;
    end
  end

  // Read selection
  // code per subindex
  always_comb begin
    rd_code = 32'h0;
    for (int i = 0; i < DEPTH; i++) begin
      if (rd_sub == 8'(i + 1)) begin
        rd_code = mem[i];
      end
    end
  end

  assign rd_hit = (rd_sub != 8'h00) && (rd_sub <= count);

  chk_clear_empties : assert property (@(posedge mclk) disable iff (sys_rst)
    clear && !rec_valid |=> count == 8'h00)
    else $error("history count not zero after clear");

endmodule // dess_history

// ===== bench/dess_master.sv
// Master controller model that issues object accesses to the drive
`timescale 1ns/1ns
module dess_master (
  input  logic        mclk,
  output logic        req_valid,
  output logic        req_write,
  output logic [15:0] req_index,
  output logic [7:0]  req_subindex,
  output logic [31:0] req_data,
  input  logic        rsp_valid,
  input  logic [7:0]  rsp_cmd,
  input  logic [31:0] rsp_data
);
  // Idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_index = 16'h0000;
    req_subindex = 8'h00;
    req_data = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle request pulse after an optional idle gap, answer awaited for 8 cycles
  // master reads and writes answered
  task automatic access(input int gap, input logic w, input logic [15:0] idx,
                        input logic [7:0] sub, input logic [31:0] d,
                        output logic [7:0] cmd, output logic [31:0] dat, output bit ok);
    int i;
    ok = 1'b0;
    repeat (gap) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = w;
    req_index = idx;
    req_subindex = sub;
    req_data = d;
    for (i = 0; i < 8 && !ok; i++) begin
      @(negedge mclk);
      // Released lines show inverted values so a stale one never passes
      req_valid = 1'b0;
      req_write = ~w;
      req_index = ~idx;
      req_subindex = ~sub;
      req_data = ~d;
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        cmd = rsp_cmd;
        dat = rsp_data;
      end
    end
  endtask
endmodule // dess_master

// ===== bench/tb.sv
// Self-checking bench for the drive safety status block
`timescale 1ns/1ns
module tb;
  logic        mclk, sys_rst, req_valid, req_write, rsp_valid;
  logic        dig_in3, torque_cutoff_line_a, torque_cutoff_line_b;
  logic        run_req, standby_req, disable_req, dyn_brake_en, err_valid;
  logic        drive_running, ramp_active;
  logic [15:0] req_index, drive_state_word, drive_ctrl_code;
  logic [7:0]  req_subindex, rsp_cmd;
  logic [31:0] req_data, rsp_data, err_code, seed;
  int          n_mismatch, num_checks, st, en, pol, e3, i;
  int unsigned hq[$];
  localparam int RAMP = 8;

  dess_top #(.RAMP_CYCLES(RAMP), .HIST_DEPTH(15)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
    .req_index(req_index), .req_subindex(req_subindex), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_cmd(rsp_cmd), .rsp_data(rsp_data), .dig_in3(dig_in3),
    .torque_cutoff_line_a(torque_cutoff_line_a), .torque_cutoff_line_b(torque_cutoff_line_b),
    .run_req(run_req), .standby_req(standby_req), .disable_req(disable_req),
    .dyn_brake_en(dyn_brake_en), .err_valid(err_valid), .err_code(err_code),
    .drive_state_word(drive_state_word), .drive_ctrl_code(drive_ctrl_code),
    .drive_running(drive_running), .ramp_active(ramp_active));

  dess_master m (
    .mclk(mclk), .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_subindex(req_subindex), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_cmd(rsp_cmd), .rsp_data(rsp_data));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Model helpers: random source and expected status word
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Uses the synchronised input level e3, not the pin, so latency is checked too
  function automatic logic [15:0] ew();
    logic [15:0] w;
    w = (st == 0) ? 16'h0040 : (st == 1) ? 16'h0023 : (st == 4) ? 16'h4023 : 16'h0027;
    w[8] = (en != 0) && ((e3 ^ pol) != 0);
    return w;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic pins();
    chk("state word", {16'h0000, drive_state_word}, {16'h0000, ew()});
    chk("running", {31'h0, drive_running}, {31'h0, st == 2});
    chk("ramp", {31'h0, ramp_active}, {31'h0, st == 3});
  endtask

  // Object access; an expected command of zero means the width code is not checked
  task automatic sdo(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] d, input logic [7:0] ec, input logic [31:0] ed);
    logic [7:0]  c;
    logic [31:0] v;
    bit          ok;
    m.access(int'(xs() % 3), w, idx, sub, d, c, v, ok);
    if (!ok) begin
      n_mismatch++;
      $display("ERROR answer expected 1 seen 0");
      results();
    end
    if (ec != 8'h00)
      chk("answer cmd", {24'h0, c}, {24'h0, ec});
    chk("answer data", v, ed);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Command pulse: 0 standby, 1 run, 2 disable
  task automatic cmd(input int k);
    @(negedge mclk);
    standby_req = (k == 0);
    run_req = (k == 1);
    disable_req = (k == 2);
    @(negedge mclk);
    standby_req = 1'b0;
    run_req = 1'b0;
    disable_req = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h0000_0021;
    n_mismatch = 0;
    num_checks = 0;
    st = 0;
    en = 0;
    pol = 0;
    e3 = 0;
    sys_rst = 1'b1;
    dig_in3 = 1'b0;
    torque_cutoff_line_a = 1'b1;
    torque_cutoff_line_b = 1'b1;
    run_req = 1'b0;
    standby_req = 1'b0;
    disable_req = 1'b0;
    dyn_brake_en = 1'b0;
    err_valid = 1'b0;
    err_code = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    pins();
    sdo(0, 16'h6041, 8'h00, 0, 8'h4b, 32'h0040);
    sdo(0, 16'h1234, 8'h00, 0, 8'h80, 32'h0602_0000);
    sdo(1, 16'h6041, 8'h00, 0, 8'h80, 32'h0601_0002);
    $display("test reset done");
    // Emergency input has no effect until the function is switched on
    dig_in3 = 1'b1;
    e3 = 1;
    cmd(0);
    st = 1;
    cmd(1);
    st = 2;
    pins();
    sdo(0, 16'h3008, 8'h03, 0, 8'h4b, 0);
    sdo(1, 16'h3008, 8'h01, 1, 8'h60, 0);
    en = 1;
    st = 1;
    cyc(3);
    pins();
    sdo(0, 16'h6041, 8'h00, 0, 8'h4b, 32'h0123);
    sdo(0, 16'h3008, 8'h03, 0, 8'h4b, 1);
    cmd(1);
    pins();
    $display("test emergency done");
    // Inverted polarity, with the synchroniser depth observed on the way
    sdo(1, 16'h3008, 8'h02, 1, 8'h60, 0);
    pol = 1;
    cyc(3);
    pins();
    dig_in3 = 1'b0;
    cyc(2);
    pins();
    cyc(1);
    e3 = 0;
    pins();
    dig_in3 = 1'b1;
    cyc(3);
    e3 = 1;
    cmd(1);
    st = 2;
    pins();
    $display("test polarity done");
    // Emergency exit with the brake option runs a bounded ramp before standby
    dyn_brake_en = 1'b1;
    dig_in3 = 1'b0;
    cyc(3);
    e3 = 0;
    st = 3;
    pins();
    for (i = 0; i < 20 && ramp_active === 1'b1; i++)
      cyc(0);
    st = 1;
    pins();
    chk("ramp length", i, RAMP);
    dig_in3 = 1'b1;
    dyn_brake_en = 1'b0;
    cyc(3);
    e3 = 1;
    $display("test ramp done");
    // Torque cutoff on line a from the run state, then on line b from disabled
    cmd(1);
    st = 2;
    torque_cutoff_line_a = 1'b0;
    cyc(2);
    pins();
    cyc(1);
    st = 4;
    pins();
    chk("ctrl code", {16'h0000, drive_ctrl_code}, 32'h80);
    cmd(1);
    pins();
    sdo(0, 16'h4000, 8'h01, 0, 8'h4b, 1);
    sdo(0, 16'h2002, 8'h00, 0, 8'h4b, 32'h0080);
    sdo(0, 16'h6041, 8'h00, 0, 8'h4b, 32'h4023);
    torque_cutoff_line_a = 1'b1;
    cyc(3);
    st = 0;
    pins();
    sdo(0, 16'h4000, 8'h01, 0, 8'h4b, 0);
    torque_cutoff_line_b = 1'b0;
    cyc(3);
    st = 4;
    pins();
    torque_cutoff_line_b = 1'b1;
    cyc(3);
    st = 0;
    pins();
    // Standby from run, then disable from standby
    cmd(0);
    st = 1;
    cmd(1);
    st = 2;
    cmd(0);
    st = 1;
    pins();
    cmd(2);
    st = 0;
    pins();
    $display("test cutoff done");
    // History: record, read newest first, empty slots, refused and real clear
    for (i = 0; i < 3; i++) begin
      @(negedge mclk);
      err_code = xs();
      err_valid = 1'b1;
      hq.push_front(err_code);
      @(negedge mclk);
      err_valid = 1'b0;
    end
    sdo(0, 16'h1003, 8'h00, 0, 8'h4f, hq.size());
    for (i = 1; i <= 3; i++)
      sdo(0, 16'h1003, i[7:0], 0, 8'h43, hq[i - 1]);
    sdo(0, 16'h1003, 8'h04, 0, 8'h80, 32'h0609_0011);
    sdo(0, 16'h1003, 8'h0f, 0, 8'h80, 32'h0609_0011);
    sdo(1, 16'h1003, 8'h00, xs() | 32'h1, 8'h80, 32'h0609_0030);
    sdo(1, 16'h1003, 8'h00, 0, 8'h60, 0);
    hq.delete();
    sdo(0, 16'h1003, 8'h00, 0, 8'h4f, 0);
    sdo(0, 16'h1003, 8'h01, 0, 8'h80, 32'h0609_0011);
    $display("test history done");
    results();
  end
endmodule // tb
